// [src/usb_accessory_detect_control.sv]
// Accessory detection control: triggers, timing, flags and reset sources
`timescale 1ns/1ps
// Behaviour
// - Supply change or ID float change starts a detection flow.
// - Detach changes supply or ID, so the flow runs again.
// - Host clearing a set active bit starts a new flow.
// - Flow completion raises an interrupt to the host.
// - Interrupt pin is open-drain, pulled low while an event is pending.
// - Interrupt pin releases when the interrupt bits are read or the device is reset.
// - Falling edge on IO supply resets the whole device except the reset supervisor.
// - I2C clock and data lines form a second reset source.
// - Both I2C lines low 13.5 ms resets; 8.8 ms or less does not.
// - Device is only an I2C slave reaching status and control.
// - Host selects USB, UART or audio paths; device applies them.
// - Supply accessory turns on the charger power transistor.
// - Open-drain charge current output shows supply capability.
// - Supply detector reports presence and removal to the state machine.
// - ID detector reports whether a resistor sits on the ID pin.
// - ID resistance is measured with a 5-bit converter.
// - Conversion result is stored readable; the attach decision does not use it.
// - ID going to float is deglitched 20 ms before acceptance; a resistor appearing starts conversion at once.
// - ID detection waits (code+1)*100 ms after supply; default code 4.
`include "acc_defs.svh"
module usb_accessory_detect_control import acc_pkg::*; #(
  parameter int STEP_CYC = `T_STEP_MS * `OSC_KHZ  // Delay step in osc cycles
) (
  input  wire logic       clk,                 // Host side clock
  input  wire logic       sys_rst,             // Async reset, high
  input  wire logic       osc_clk,             // Low-frequency oscillator
  input  wire logic       vbus_det,            // Supply present, async
  input  wire logic       id_float,            // No ID resistor, async
  input  wire logic       supply_hicap,        // Supply high capability, async
  input  wire logic [4:0] adc_code,            // Converter result, osc domain
  output logic            adc_start,           // Converter running
  input  wire logic       io_supply_input,     // IO supply level, async
  input  wire logic       scl_i,               // I2C clock level
  input  wire logic       sda_i,               // I2C data level
  input  wire logic       active_clr,          // Host writes active to 0
  input  wire logic       td_wr,               // Delay setting write
  input  wire logic [3:0] id_delay_select,     // Delay setting data
  input  wire logic       sw_wr,               // Switch path write
  input  wire sw_path_t   sw_sel,              // Switch path data
  input  wire logic       flags_rd,            // Host reads flags
  output irq_flags_t      flags_o,             // Interrupt flags
  output det_res_t        status_o,            // Last identification
  output logic            active_o,            // Active bit
  output sw_path_t        sw_path_o,           // Applied switch paths
  output logic            int_o,               // Interrupt pin level
  output logic            int_oe_n,            // Interrupt pin drive, low
  output logic            charge_current_sel_o,     // Charge pin level
  output logic            charge_current_sel_oe_n,  // Charge pin drive, low
  output logic            power_fet_on         // Charger power switch
);
  localparam int CONV_CYC = (`T_CONV_US * `OSC_KHZ + 999) / 1000;
  localparam int FLT_CYC  = `T_FLOAT_MS * `OSC_KHZ;
  localparam int RST_CYC  = (`T_I2C_RST_US * `OSC_KHZ + 999) / 1000;
  localparam int NRST_CYC = `T_I2C_NRST_US * `OSC_KHZ / 1000;
  localparam int CW = `CNT_W;
  localparam int LW = `LOW_W;

  // Reset supervisor, osc domain, cleared only by sys_rst
  logic [1:0]    io_s_q;
  logic [1:0]    scl_s_q;
  logic [1:0]    sda_s_q;
  logic          io_d_q;
  logic [LW-1:0] low_q;
  logic          dev_rst_q;
  wire           both_low = !scl_s_q[1] && !sda_s_q[1];
  wire           io_fall  = io_d_q && !io_s_q[1];
  wire           low_hit  = both_low && (low_q == LW'(RST_CYC - 1));

  always_ff @(posedge osc_clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_s_q    <= 2'h0;
      scl_s_q   <= 2'h3;
      sda_s_q   <= 2'h3;
      io_d_q    <= 1'b0;
      low_q     <= '0;
      dev_rst_q <= 1'b0;
    end else begin
      io_s_q    <= {io_s_q[0], io_supply_input};
      scl_s_q   <= {scl_s_q[0], scl_i};
      sda_s_q   <= {sda_s_q[0], sda_i};
      io_d_q    <= io_s_q[1];
      low_q     <= !both_low ? '0 : (low_hit ? low_q : low_q + LW'(1));
      dev_rst_q <= io_fall || low_hit;
    end
  end

  wire        core_rst = sys_rst || dev_rst_q;
  logic [1:0] orst_q;
  logic [1:0] crst_q;
  wire        rst_o = orst_q[1];
  wire        rst_c = crst_q[1];

  always_ff @(posedge osc_clk or posedge core_rst) begin
    if (core_rst) orst_q <= 2'h3;
    else orst_q <= {orst_q[0], 1'b0};
  end

  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) crst_q <= 2'h3;
    else crst_q <= {crst_q[0], 1'b0};
  end

  // Detection engine, osc domain
  logic [1:0]    vb_s_q;
  logic [1:0]    fl_s_q;
  logic [1:0]    cap_s_q;
  logic [1:0]    rq_s_q;
  logic [3:0]    td_a_q;
  logic [3:0]    td_b_q;
  logic          vb_d_q;
  logic          fl_d_q;
  logic          rq_d_q;
  det_st_t       st_q;
  det_st_t       st_d;
  det_st_t       st_start;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] cnt_start;
  logic [4:0]    code_q;
  det_res_t      res_q;
  logic          done_tg_q;
  logic          chg_n_q;
  logic          rq_tg_q;
  logic [3:0]    td_q;

  wire vb      = vb_s_q[1];
  wire fl      = fl_s_q[1];
  wire vb_chg  = vb ^ vb_d_q;
  wire fl_chg  = fl ^ fl_d_q;
  wire rq_evt  = rq_s_q[1] ^ rq_d_q;
  wire trig    = vb_chg || fl_chg || rq_evt;
  wire cnt_end = (cnt_q == '0);
  wire [CW-1:0] td_load = CW'((int'(td_b_q) + 1) * STEP_CYC - 1);

  assign st_start  = (vb_chg && vb) ? ST_VWAIT : ((fl_chg && fl) ? ST_FLT : ST_CONV);
  assign cnt_start = (st_start == ST_VWAIT) ? td_load :
                     ((st_start == ST_FLT) ? CW'(FLT_CYC - 1) : CW'(CONV_CYC - 1));
  assign adc_start = (st_q == ST_CONV);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_end ? cnt_q : cnt_q - CW'(1);
    if (trig) begin
      st_d  = st_start;
      cnt_d = cnt_start;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_DONE: st_d = ST_IDLE;
        ST_VWAIT, ST_FLT: begin
          if (cnt_end) begin
            st_d  = fl ? ST_DONE : ST_CONV;
            cnt_d = CW'(CONV_CYC - 1);
          end
        end
        ST_CONV: begin
          if (cnt_end) st_d = ST_DONE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge osc_clk or posedge rst_o) begin
    if (rst_o) begin
      vb_s_q    <= 2'h0;
      fl_s_q    <= 2'h3;
      cap_s_q   <= 2'h0;
      rq_s_q    <= 2'h0;
      td_a_q    <= `TD_RST;
      td_b_q    <= `TD_RST;
      vb_d_q    <= 1'b0;
      fl_d_q    <= 1'b1;
      rq_d_q    <= 1'b0;
      st_q      <= ST_IDLE;
      cnt_q     <= '0;
      code_q    <= 5'h0;
      res_q     <= '0;
      done_tg_q <= 1'b0;
      chg_n_q   <= 1'b1;
    end else begin
      vb_s_q  <= {vb_s_q[0], vbus_det};
      fl_s_q  <= {fl_s_q[0], id_float};
      cap_s_q <= {cap_s_q[0], supply_hicap};
      rq_s_q  <= {rq_s_q[0], rq_tg_q};
      td_a_q  <= td_q;
      td_b_q  <= td_a_q;
      vb_d_q  <= vb;
      fl_d_q  <= fl;
      rq_d_q  <= rq_s_q[1];
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      if (st_q == ST_CONV && cnt_end) code_q <= adc_code;
      if (st_q == ST_DONE) begin
        res_q     <= '{code: code_q, attached: vb || !fl, vbus: vb, no_id: fl,
                       hi_cur: vb && cap_s_q[1]};
        chg_n_q   <= !(vb && !cap_s_q[1]);
        done_tg_q <= !done_tg_q;
      end
    end
  end

  assign power_fet_on            = res_q.vbus;
  assign charge_current_sel_o    = 1'b0;
  assign charge_current_sel_oe_n = chg_n_q;

  // Host side, clk domain
  logic [1:0] dn_s_q;
  logic       dn_d_q;
  det_res_t   res_c_q;
  irq_flags_t flags_q;
  irq_flags_t flags_d;
  logic       active_q;
  sw_path_t   sw_q;
  logic       int_n_q;

  wire        done_evt = dn_s_q[1] ^ dn_d_q;
  wire        restart  = active_clr && active_q;
  irq_flags_t flag_set;
  assign flag_set = '{attach: done_evt && res_q.attached,
                      detach: done_evt && !res_q.attached};
  assign flags_d  = (flags_q & {2{!flags_rd}}) | flag_set;

  always_ff @(posedge clk or posedge rst_c) begin
    if (rst_c) begin
      dn_s_q   <= 2'h0;
      dn_d_q   <= 1'b0;
      res_c_q  <= '0;
      flags_q  <= '0;
      active_q <= 1'b0;
      rq_tg_q  <= 1'b0;
      td_q     <= `TD_RST;
      sw_q     <= '0;
      int_n_q  <= 1'b1;
    end else begin
      dn_s_q  <= {dn_s_q[0], done_tg_q};
      dn_d_q  <= dn_s_q[1];
      flags_q <= flags_d;
      int_n_q <= (flags_d == '0);
      if (done_evt) res_c_q <= res_q;
      if (done_evt) active_q <= res_q.attached;
      else if (active_clr) active_q <= 1'b0;
      if (restart) rq_tg_q <= !rq_tg_q;
      if (td_wr) td_q <= id_delay_select;
      if (done_evt && !res_q.attached) sw_q <= '0;
      else if (sw_wr) sw_q <= sw_sel;
    end
  end

  assign flags_o   = flags_q;
  assign status_o  = res_c_q;
  assign active_o  = active_q;
  assign sw_path_o = sw_q;
  assign int_o     = 1'b0;
  assign int_oe_n  = int_n_q;

  // Checks
  property p_int_on_done;
    @(posedge clk) disable iff (rst_c) done_evt |=> !int_oe_n;
  endproperty
  a_int_on_done: assert property (p_int_on_done) else $error("no interrupt");

  property p_int_release;
    @(posedge clk) disable iff (rst_c) flags_rd && !done_evt |=> int_oe_n && flags_o == '0;
  endproperty
  a_int_release: assert property (p_int_release) else $error("int kept");

  property p_int_level;
    @(posedge clk) disable iff (rst_c) (flags_o != '0) == !int_oe_n;
  endproperty
  a_int_level: assert property (p_int_level) else $error("int level");

  property p_restart;
    @(posedge clk) disable iff (rst_c) restart |=> rq_tg_q != $past(rq_tg_q);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_trig_start;
    @(posedge osc_clk) disable iff (rst_o)
      vb_chg && vb |=> st_q == ST_VWAIT && cnt_q == $past(td_load);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("no flow");

  property p_conv_len;
    @(posedge osc_clk) disable iff (rst_o)
      st_q == ST_CONV |-> cnt_q < CW'(CONV_CYC) &&
        ($past(st_q) == ST_CONV || cnt_q == CW'(CONV_CYC - 1));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conv long");

  property p_float_dg;
    @(posedge osc_clk) disable iff (rst_o)
      fl_chg && fl && !vb_chg |=> st_q == ST_FLT && cnt_q == CW'(FLT_CYC - 1);
  endproperty
  a_float_dg: assert property (p_float_dg) else $error("float dg");

  property p_result;
    @(posedge osc_clk) disable iff (rst_o)
      st_q == ST_CONV && cnt_end && !trig |=> ##1 res_q.code == $past(adc_code, 2);
  endproperty
  a_result: assert property (p_result) else $error("bad result");

  property p_i2c_rst;
    @(posedge osc_clk) disable iff (sys_rst)
      both_low && low_q == LW'(RST_CYC - 1) |=> dev_rst_q;
  endproperty
  a_i2c_rst: assert property (p_i2c_rst) else $error("no i2c reset");

  property p_i2c_nrst;
    @(posedge osc_clk) disable iff (sys_rst)
      low_q <= LW'(NRST_CYC) && !io_fall |=> !dev_rst_q;
  endproperty
  a_i2c_nrst: assert property (p_i2c_nrst) else $error("early reset");

  property p_io_rst;
    @(posedge osc_clk) disable iff (sys_rst) io_fall |=> dev_rst_q;
  endproperty
  a_io_rst: assert property (p_io_rst) else $error("no io reset");
endmodule

// [src/acc_defs.svh]
// Timing, reset and layout constants for the accessory detection control
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define OSC_KHZ        100
`define T_CONV_US      1000
`define T_FLOAT_MS     20
`define T_STEP_MS      100
`define T_I2C_RST_US   13500
`define T_I2C_NRST_US  8800
`define TD_RST         4'h4
`define CNT_W          18
`define LOW_W          11
`endif

// [src/acc_pkg.sv]
// Types shared by the accessory detection control
package acc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_VWAIT = 5'b00010,
    ST_FLT   = 5'b00100,
    ST_CONV  = 5'b01000,
    ST_DONE  = 5'b10000
  } det_st_t;

  typedef struct packed {
    logic [4:0] code;
    logic       attached;
    logic       vbus;
    logic       no_id;
    logic       hi_cur;
  } det_res_t;

  typedef struct packed {
    logic usb;
    logic uart;
    logic audio;
  } sw_path_t;

  typedef struct packed {
    logic attach;
    logic detach;
  } irq_flags_t;
endpackage

// [tb/id_adc_model.sv]
// Converter model on the far side of the detection block
`timescale 1ns/1ps
module id_adc_model #(
  parameter logic [4:0] CODE = 5'h13  // Measured value
) (
  input  wire logic       osc_clk,    // Converter clock
  input  wire logic       adc_start,  // Conversion running
  output logic      [4:0] adc_code,   // Result
  output int              conv_len    // Length of last run
);
  logic run;
  initial begin
    adc_code = 5'h00;
    conv_len = 0;
    run = 1'b0;
  end
  always @(posedge osc_clk) begin
    run <= adc_start;
    if (adc_start) begin
      adc_code <= CODE;
      conv_len <= run ? conv_len + 1 : 1;
    end else begin
      // Idle value keeps changing so a stale sample shows
      adc_code <= ~adc_code;
    end
  end
endmodule

// [tb/usb_accessory_detect_control_tb.sv]
// Testbench for the accessory detection control
`timescale 1ns/1ps
module usb_accessory_detect_control_tb import acc_pkg::*;;
  logic       clk, sys_rst, osc_clk, vbus_det, id_float, supply_hicap, io_supply_input;
  logic       scl_i, sda_i, active_clr, td_wr, sw_wr, flags_rd, adc_start, active_o;
  logic       int_o, int_oe_n, chg_o, chg_oe_n, power_fet_on;
  logic [3:0] id_delay_select;
  logic [4:0] adc_code;
  sw_path_t   sw_sel, sw_path_o;
  irq_flags_t flags_o;
  det_res_t   status_o;
  int         conv_len, bad_count, checks_done;
  wire        int_pin = int_oe_n ? 1'b1 : int_o;
  wire        chg_pin = chg_oe_n ? 1'b1 : chg_o;

  usb_accessory_detect_control #(.STEP_CYC(20)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .osc_clk(osc_clk), .vbus_det(vbus_det),
    .id_float(id_float), .supply_hicap(supply_hicap), .adc_code(adc_code),
    .adc_start(adc_start), .io_supply_input(io_supply_input), .scl_i(scl_i),
    .sda_i(sda_i), .active_clr(active_clr), .td_wr(td_wr),
    .id_delay_select(id_delay_select), .sw_wr(sw_wr), .sw_sel(sw_sel),
    .flags_rd(flags_rd), .flags_o(flags_o), .status_o(status_o), .active_o(active_o),
    .sw_path_o(sw_path_o), .int_o(int_o), .int_oe_n(int_oe_n),
    .charge_current_sel_o(chg_o), .charge_current_sel_oe_n(chg_oe_n),
    .power_fet_on(power_fet_on));

  id_adc_model adc_u (
    .osc_clk(osc_clk), .adc_start(adc_start), .adc_code(adc_code), .conv_len(conv_len));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    osc_clk = 1'b0;
    #2;
    forever #32 osc_clk = ~osc_clk;
  end

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Host pulse: {active_clr, td_wr, sw_wr, flags_rd}
  task automatic hp(input logic [3:0] m);
    @(negedge clk);
    {active_clr, td_wr, sw_wr, flags_rd} = m;
    @(negedge clk);
    {active_clr, td_wr, sw_wr, flags_rd} = 4'h0;
    repeat (3) @(negedge clk);
  endtask

  task automatic ow(input int n);
    repeat (n) @(posedge osc_clk);
    @(negedge clk);
  endtask

  task automatic wf(input int i);
    int n;
    n = 0;
    while (flags_o[i] !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n == 30000) begin
      bad_count++;
      $display("unexpected flag wait: expected 1, seen %b", flags_o[i]);
      test_done();
    end
    repeat (4) @(negedge clk);
  endtask

  initial begin
    bad_count = 0;
    checks_done = 0;
    {sys_rst, io_supply_input, scl_i, sda_i} = 4'hf;
    {vbus_det, id_float, supply_hicap, active_clr, td_wr, sw_wr, flags_rd} = 7'h00;
    id_delay_select = 4'h1;
    sw_sel = 3'b101;
    repeat (2) @(posedge clk);
    repeat (3) @(posedge osc_clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("flags", 10'h0, flags_o);
    chk("int pin", 10'h1, int_pin);
    chk("status", 10'h0, status_o);
    chk("outs", 10'h01, {active_o, sw_path_o, power_fet_on, chg_oe_n});
    hp(4'h4);
    vbus_det = 1'b1;
    ow(38);
    chk("adc_start early", 10'h0, adc_start);
    ow(12);
    chk("adc_start", 10'h1, adc_start);
    wf(1);
    chk("conv len", 10'd100, conv_len[9:0]);
    chk("status", {5'h13, 4'b1100}, status_o);
    chk("fet", 10'h1, power_fet_on);
    chk("chg pin", 10'h0, chg_pin);
    chk("int pin", 10'h0, int_pin);
    chk("active", 10'h1, active_o);
    hp(4'h2);
    chk("paths", 10'h5, sw_path_o);
    hp(4'h1);
    chk("flags", 10'h0, flags_o);
    chk("int pin", 10'h1, int_pin);
    hp(4'h8);
    wf(1);
    chk("int pin", 10'h0, int_pin);
    hp(4'h1);
    vbus_det = 1'b0;
    wf(1);
    chk("supply outs", 10'h1, {power_fet_on, chg_oe_n});
    hp(4'h1);
    id_float = 1'b1;
    ow(1900);
    chk("flags", 10'h0, flags_o);
    wf(0);
    chk("status", {5'h13, 4'b0010}, status_o);
    chk("paths", 10'h0, sw_path_o);
    chk("active", 10'h0, active_o);
    hp(4'h1);
    // Clearing an inactive bit must not restart a flow
    hp(4'h8);
    ow(110);
    chk("flags", 10'h0, flags_o);
    {scl_i, sda_i} = 2'b00;
    ow(800);
    {scl_i, sda_i} = 2'b11;
    ow(5);
    chk("status", {5'h13, 4'b0010}, status_o);
    {scl_i, sda_i} = 2'b00;
    ow(1400);
    {scl_i, sda_i} = 2'b11;
    ow(5);
    chk("status", 10'h0, status_o);
    id_float = 1'b0;
    wf(1);
    // High-current supply after reset, default delay code
    hp(4'h1);
    supply_hicap = 1'b1;
    vbus_det = 1'b1;
    ow(95);
    chk("adc_start default", 10'h0, adc_start);
    ow(12);
    chk("adc_start default", 10'h1, adc_start);
    wf(1);
    chk("status", {5'h13, 4'b1101}, status_o);
    chk("chg pin", 10'h1, chg_pin);
    chk("fet", 10'h1, power_fet_on);
    io_supply_input = 1'b0;
    ow(6);
    chk("status", 10'h0, status_o);
    chk("int pin", 10'h1, int_pin);
    chk("fet", 10'h0, power_fet_on);
    chk("chg pin", 10'h1, chg_pin);
    io_supply_input = 1'b1;
    ow(4);
    test_done();
  end
endmodule
